// *** rtl/swafh_pkg.sv ***
// shared constants, types and helpers for the two-wire debug link
// Function
// RQ1: every access opens with a request header
// RQ2: host samples a three-bit acknowledge
// RQ3: bad header gets no answer, line released
// RQ4: write acknowledge precedes write parity check
// RQ5: bad write parity sets write parity flag
// RQ6: host captures read word, checks parity
// RQ7: host re-fetches bad read via resend
// RQ8: host sends write word after OK
// RQ9: no data phase on WAIT/FAULT unless overrun
// RQ10: host repeats request after WAIT
// RQ11: after FAULT only addresses 0/1 answered
// RQ12: no acknowledge: host backs off
// RQ13: invalid read acknowledge: host backs off
// RQ14: invalid write acknowledge: back off, repeat
// RQ15: repeated write handled independently of first
// RQ16: exactly one port, serial variant
// RQ17: serial variant has wire control, resend
// RQ18: route select slot stays reserved
// RQ19: resend returns last delivered read value
package swafh_pkg;
  // acknowledge codes, bit 0 goes first on the wire
  localparam logic [2:0] ACK_OK = 3'h1;
  localparam logic [2:0] ACK_WAIT = 3'h2;
  localparam logic [2:0] ACK_FAULT = 3'h4;
  localparam int HDR_BITS = 8;
  localparam int DATA_BITS = 33;
  localparam int BACKOFF_BITS = 34;
  // header bit positions in wire order
  localparam int H_START = 0;
  localparam int H_APNDP = 1;
  localparam int H_RNW = 2;
  localparam int H_A2 = 3;
  localparam int H_A3 = 4;
  localparam int H_PAR = 5;
  localparam int H_STOP = 6;
  localparam int H_PARK = 7;
  // port register addresses
  localparam logic [1:0] A_ID_ABORT = 2'h0;
  localparam logic [1:0] A_CTRL_WCR = 2'h1;
  localparam logic [1:0] A_RESEND_SEL = 2'h2;
  localparam logic [1:0] A_READ_BUFFER_REG = 2'h3;
  // control/status fields
  localparam int CS_ORUNDETECT = 0;
  localparam int CS_STICKYORUN = 1;
  localparam int CS_STICKYERR = 5;
  localparam int CS_READOK = 6;
  localparam int CS_WPARERR = 7;
  // abort fields
  localparam int AB_APABORT = 0;
  localparam int AB_STKERRCLR = 2;
  localparam int AB_WPERRCLR = 3;
  localparam int AB_ORUNCLR = 4;
  localparam int SEL_CTRLSEL = 0;
  localparam logic [31:0] WCR_RESET = 32'h0000_0000;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  typedef enum logic [6:0] {
    D_IDLE = 7'h01, D_HDR = 7'h02, D_TA = 7'h04, D_ACK = 7'h08,
    D_RD = 7'h10, D_WTA = 7'h20, D_WD = 7'h40
  } swafh_dstate_e;

  typedef enum logic [8:0] {
    H_IDLE = 9'h001, H_HDR = 9'h002, H_TA = 9'h004, H_ACK = 9'h008, H_RD = 9'h010,
    H_WTA = 9'h020, H_WD = 9'h040, H_BACK = 9'h080, H_END = 9'h100
  } swafh_hstate_e;

  function automatic logic [7:0] swafh_mk_hdr(input logic ap, input logic rnw,
                                              input logic [1:0] a);
    swafh_mk_hdr = {1'b1, 1'b0, ap ^ rnw ^ a[1] ^ a[0], a[1], a[0], rnw, ap, 1'b1};
  endfunction : swafh_mk_hdr
endpackage : swafh_pkg

// *** rtl/swafh_link_if.sv ***
// two-wire link between debugger host and debug port
`timescale 1ns/1ps
interface swafh_link_if;
  logic swclk;
  logic host_out;
  logic host_oe;
  logic dev_out;
  logic dev_oe;
  logic line;
  // weak pull-down: an unanswered acknowledge reads as 000
  assign line = host_oe ? host_out : (dev_oe ? dev_out : 1'b0);
  modport host (output swclk, output host_out, output host_oe, input line);
  modport dev (input swclk, input line, output dev_out, output dev_oe);
endinterface : swafh_link_if

// *** rtl/swafh_dev.sv ***
// serial debug port end: header check, acknowledge, registers, fault handling
`timescale 1ns/1ps
module swafh_dev #(
  parameter logic [31:0] ID_VALUE = 32'h1234_5671 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // link
  swafh_link_if.dev link,
  // access port side
  output logic ap_req,
  output logic ap_rnw,
  output logic [1:0] ap_addr,
  output logic [31:0] ap_wdata,
  input wire logic ap_done,
  input wire logic ap_err,
  input wire logic [31:0] ap_rdata,
  // status
  output logic write_parity_error_flag,
  output logic sticky_err_flag
);
  import swafh_pkg::*;

  swafh_dstate_e state;
  logic clk_s1, clk_s2, clk_s3, dio_s1, dio_s2;
  logic rise;
  logic [5:0] cnt;
  logic [6:0] hdr;
  logic [6:0] f;
  logic hdr_end, hdr_ok, wr_end, data_phase;
  logic [2:0] ack_now, ack_q;
  logic req_ap, req_rnw;
  logic [1:0] req_a;
  logic [32:0] word, wsh, wfull;
  logic orun_en, sticky_orun, readok, ap_busy;
  logic [31:0] wire_control_reg, sel, read_buffer_reg, resend_val, rd_value;
  logic dev_out, dev_oe;

  ////////////////////////////////////////////////////////////////////////
  // decoding shared by the response and the register effects
  function automatic logic [2:0] ack_for(input logic ap, input logic [1:0] a,
                                         input logic sticky, input logic busy);
    if (!ap && !a[1]) begin
      ack_for = ACK_OK; // see RQ11
    end else if (sticky) begin
      ack_for = ACK_FAULT;
    end else if (busy) begin
      ack_for = ACK_WAIT;
    end else begin
      ack_for = ACK_OK;
    end
  endfunction : ack_for

  ////////////////////////////////////////////////////////////////////////
  // link inputs cross into clk through two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dio_s1 <= 1'b0;
      dio_s2 <= 1'b0;
    end else if (ce) begin
      clk_s1 <= link.swclk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dio_s1 <= link.line;
      dio_s2 <= dio_s1;
    end
  end

  assign rise = ce && clk_s2 && !clk_s3;
  assign f = {dio_s2, hdr[6:1]};
  assign hdr_end = rise && (state == D_HDR) && (cnt == 6'(HDR_BITS - 2));
  // start bit was consumed in idle, so f holds bits 1..7
  assign hdr_ok = (f[H_PAR-1] == ^f[H_A3-1:H_APNDP-1]) && !f[H_STOP-1] && f[H_PARK-1];
  assign ack_now = ack_for(f[H_APNDP-1], f[H_A3-1:H_A2-1],
                           sticky_err_flag | write_parity_error_flag | sticky_orun, ap_busy);
  assign wfull = {dio_s2, wsh[32:1]};
  assign wr_end = rise && (state == D_WD) && (cnt == 6'(DATA_BITS - 1));
  assign data_phase = (ack_q == ACK_OK) || orun_en; // see RQ9

  // single serial-variant port; no scan chain variant behind it
  always_comb begin
    rd_value = read_buffer_reg; // see RQ16
    if (!f[H_APNDP-1]) begin
      unique case (f[H_A3-1:H_A2-1])
        A_ID_ABORT: rd_value = ID_VALUE;
        A_CTRL_WCR: rd_value = sel[SEL_CTRLSEL] ? wire_control_reg : // see RQ17
          {24'h00_0000, write_parity_error_flag, readok, sticky_err_flag,
           3'h0, sticky_orun, orun_en};
        A_RESEND_SEL: rd_value = resend_val; // see RQ19
        A_READ_BUFFER_REG: rd_value = read_buffer_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= D_IDLE;
      cnt <= 6'h00;
      hdr <= 7'h00;
      ack_q <= 3'h0;
      req_ap <= 1'b0;
      req_rnw <= 1'b0;
      req_a <= 2'h0;
      wsh <= 33'h0_0000_0000;
    end else if (rise) begin
      unique case (state)
        D_IDLE: begin
          cnt <= 6'h00;
          if (dio_s2) begin
            state <= D_HDR; // see RQ1
          end
        end
        D_HDR: begin
          hdr <= f;
          cnt <= cnt + 6'h01;
          if (hdr_end) begin
            // a malformed header is dropped silently
            state <= hdr_ok ? D_TA : D_IDLE; // see RQ3
            ack_q <= ack_now;
            req_ap <= f[H_APNDP-1];
            req_rnw <= f[H_RNW-1];
            req_a <= f[H_A3-1:H_A2-1];
          end
        end
        D_TA: begin
          state <= D_ACK;
          cnt <= 6'h00;
        end
        D_ACK: begin
          cnt <= cnt + 6'h01;
          if (cnt == 6'h02) begin
            cnt <= 6'h00;
            if (!data_phase) begin
              state <= D_IDLE; // see RQ9
            end else begin
              state <= req_rnw ? D_RD : D_WTA;
            end
          end
        end
        D_RD: begin
          cnt <= cnt + 6'h01;
          if (cnt == 6'(DATA_BITS - 1)) begin
            state <= D_IDLE;
          end
        end
        D_WTA: begin
          state <= D_WD;
          cnt <= 6'h00;
        end
        D_WD: begin
          wsh <= wfull;
          cnt <= cnt + 6'h01;
          if (wr_end) begin
            state <= D_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line driver: acknowledge then read word, released otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_out <= 1'b0;
      dev_oe <= 1'b0;
      word <= 33'h0_0000_0000;
    end else if (rise) begin
      if (hdr_end) begin
        // refused reads with overrun detection still clock out zeros
        word <= (ack_now == ACK_OK) ? {^rd_value, rd_value} : 33'h0_0000_0000;
      end
      unique case (state)
        D_TA: begin
          dev_oe <= 1'b1; // see RQ2
          dev_out <= ack_q[0];
        end
        D_ACK: begin
          if (cnt != 6'h02) begin
            // a one-bit index sum would wrap and resend bit 0
            dev_out <= (cnt == 6'h00) ? ack_q[1] : ack_q[2];
          end else if (data_phase && req_rnw) begin
            dev_out <= word[0];
          end else begin
            dev_oe <= 1'b0;
          end
        end
        D_RD: begin
          word <= word >> 1;
          dev_out <= word[1];
          if (cnt == 6'(DATA_BITS - 1)) begin
            dev_oe <= 1'b0;
          end
        end
        default: begin
          dev_oe <= 1'b0; // see RQ3
        end
      endcase
    end
  end

  assign link.dev_out = dev_out;
  assign link.dev_oe = dev_oe;

  ////////////////////////////////////////////////////////////////////////
  // register effects of reads and writes
  always_ff @(posedge clk) begin
    if (rst) begin
      orun_en <= 1'b0;
      sticky_orun <= 1'b0;
      sticky_err_flag <= 1'b0;
      write_parity_error_flag <= 1'b0;
      readok <= 1'b0;
      wire_control_reg <= WCR_RESET;
      sel <= SEL_RESET;
      resend_val <= 32'h0000_0000;
      read_buffer_reg <= 32'h0000_0000;
      ap_busy <= 1'b0;
      ap_req <= 1'b0;
      ap_rnw <= 1'b0;
      ap_addr <= 2'h0;
      ap_wdata <= 32'h0000_0000;
    end else if (ce) begin
      ap_req <= 1'b0;
      if (ap_done) begin
        ap_busy <= 1'b0;
        if (ap_rnw) begin
          read_buffer_reg <= ap_rdata;
        end
      end
      if (hdr_end && hdr_ok && f[H_RNW-1]) begin
        if (f[H_APNDP-1] || f[H_A3-1:H_A2-1] == A_READ_BUFFER_REG) begin
          readok <= (ack_now == ACK_OK);
          if (ack_now == ACK_OK) begin
            resend_val <= rd_value; // see RQ19
          end
        end
        if (f[H_APNDP-1] && ack_now == ACK_OK) begin
          ap_req <= 1'b1;
          ap_busy <= 1'b1;
          ap_rnw <= 1'b1;
          ap_addr <= f[H_A3-1:H_A2-1];
        end
      end
      // write is judged only after its acknowledge has gone out
      if (wr_end && ack_q == ACK_OK && (wfull[32] == ^wfull[31:0])) begin // see RQ4
        if (req_ap) begin
          ap_req <= 1'b1;
          ap_busy <= 1'b1;
          ap_rnw <= 1'b0;
          ap_addr <= req_a;
          ap_wdata <= wfull[31:0];
        end else begin
          unique case (req_a)
            A_ID_ABORT: begin
              if (wfull[AB_APABORT]) begin
                ap_busy <= 1'b0;
              end
              if (wfull[AB_STKERRCLR]) begin
                sticky_err_flag <= 1'b0;
              end
              if (wfull[AB_WPERRCLR]) begin
                write_parity_error_flag <= 1'b0;
              end
              if (wfull[AB_ORUNCLR]) begin
                sticky_orun <= 1'b0;
              end
            end
            A_CTRL_WCR: begin
              if (sel[SEL_CTRLSEL]) begin
                wire_control_reg <= wfull[31:0]; // see RQ17
              end else begin
                orun_en <= wfull[CS_ORUNDETECT];
              end
            end
            A_RESEND_SEL: sel <= wfull[31:0];
            // optional route select slot: reserved, write ignored
            A_READ_BUFFER_REG: sel <= sel; // see RQ18
          endcase
        end
      end
      // hardware sets come last so they win over a clear
      if (wr_end && ack_q == ACK_OK && (wfull[32] != ^wfull[31:0])) begin
        write_parity_error_flag <= 1'b1; // see RQ5
      end
      if (hdr_end && hdr_ok && ack_now == ACK_WAIT && orun_en) begin
        sticky_orun <= 1'b1;
      end
      if (ap_done && ap_err) begin
        sticky_err_flag <= 1'b1;
      end
    end
  end
  // each repeated write is decoded afresh from its own header
  // no state of a previous acknowledge carries into it (see RQ15)
endmodule : swafh_dev

// *** rtl/swafh_host.sv ***
// debugger host end: drives link clock, issues headers, reacts to acknowledge
`timescale 1ns/1ps
module swafh_host #(
  parameter int HALF = 5,
  parameter int WAIT_RETRY = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // link
  swafh_link_if.host link,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_apndp,
  input wire logic cmd_rnw,
  input wire logic [1:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic orun_en,
  // result
  output logic rsp_valid,
  output logic [2:0] rsp_ack,
  output logic [31:0] rsp_rdata,
  output logic rsp_perr
);
  import swafh_pkg::*;

  swafh_hstate_e state;
  logic [7:0] div;
  logic swclk, rise_ev, fall_ev;
  logic s1, s2;
  logic [5:0] cnt;
  logic [7:0] hdr, hdr0;
  logic [32:0] wsh, w0, rsh, rfull;
  logic [2:0] ack, a;
  logic [7:0] tries;
  logic redo, rnw, pend_out, pend_oe, out, oe;

  assign rise_ev = ce && (state != H_IDLE) && (div == 8'(HALF - 1)) && !swclk;
  assign fall_ev = ce && (state != H_IDLE) && (div == 8'(HALF - 1)) && swclk;
  assign a = {s2, ack[2:1]};
  assign rfull = {s2, rsh[32:1]};

  ////////////////////////////////////////////////////////////////////////
  // link clock divider, runs only during a transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      div <= 8'h00;
      swclk <= 1'b0;
    end else if (ce && state != H_IDLE) begin
      div <= (div == 8'(HALF - 1)) ? 8'h00 : div + 8'h01;
      if (div == 8'(HALF - 1)) begin
        swclk <= !swclk;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else if (ce) begin
      s1 <= link.line;
      s2 <= s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer: data changes on falls, samples on rises
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= H_IDLE;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_ack <= 3'h0;
      rsp_rdata <= 32'h0000_0000;
      rsp_perr <= 1'b0;
      cnt <= 6'h00;
      hdr <= 8'h00;
      hdr0 <= 8'h00;
      wsh <= 33'h0_0000_0000;
      w0 <= 33'h0_0000_0000;
      rsh <= 33'h0_0000_0000;
      ack <= 3'h0;
      tries <= 8'h00;
      redo <= 1'b0;
      rnw <= 1'b0;
      pend_out <= 1'b0;
      pend_oe <= 1'b1;
      out <= 1'b0;
      oe <= 1'b1;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      if (fall_ev) begin
        out <= pend_out;
        oe <= pend_oe;
      end
      cnt <= rise_ev ? cnt + 6'h01 : cnt;
      unique case (state)
        H_IDLE: begin
          if (cmd_valid) begin
            hdr0 <= swafh_mk_hdr(cmd_apndp, cmd_rnw, cmd_addr);
            hdr <= swafh_mk_hdr(cmd_apndp, cmd_rnw, cmd_addr);
            out <= 1'b1; // see RQ1
            w0 <= {^cmd_wdata, cmd_wdata};
            rnw <= cmd_rnw;
            tries <= 8'h00;
            redo <= 1'b0;
            cnt <= 6'h00;
            cmd_ready <= 1'b0;
            state <= H_HDR;
          end
        end
        H_HDR: begin
          if (rise_ev) begin
            hdr <= hdr >> 1;
            pend_out <= hdr[1];
            if (cnt == 6'(HDR_BITS - 1)) begin
              pend_oe <= 1'b0;
              state <= H_TA;
            end
          end
        end
        H_TA: begin
          if (rise_ev) begin
            cnt <= 6'h00;
            state <= H_ACK;
          end
        end
        H_ACK: begin
          if (rise_ev) begin
            ack <= a;
            if (cnt == 6'h02) begin
              cnt <= 6'h00;
              rsp_ack <= a; // see RQ2
              rsp_perr <= 1'b0;
              if (a == ACK_OK || ((a == ACK_WAIT || a == ACK_FAULT) && orun_en)) begin
                state <= rnw ? H_RD : H_WTA; // see RQ9
              end else if (a == ACK_WAIT && tries != 8'(WAIT_RETRY)) begin
                tries <= tries + 8'h01;
                hdr <= hdr0; // see RQ10
                pend_out <= 1'b1;
                pend_oe <= 1'b1;
                state <= H_HDR;
              end else if (a == ACK_WAIT || a == ACK_FAULT) begin
                pend_out <= 1'b0; // see RQ11
                pend_oe <= 1'b1;
                state <= H_END;
              end else begin
                state <= H_BACK; // see RQ12 RQ13
              end
            end
          end
        end
        H_RD: begin
          if (rise_ev) begin
            rsh <= rfull;
            if (cnt == 6'(DATA_BITS - 1)) begin
              cnt <= 6'h00;
              pend_oe <= 1'b1;
              rsp_rdata <= rfull[31:0]; // see RQ6
              rsp_perr <= ^rfull;
              if (^rfull && !redo && ack == ACK_OK) begin
                redo <= 1'b1;
                hdr <= swafh_mk_hdr(1'b0, 1'b1, A_RESEND_SEL); // see RQ7
                pend_out <= 1'b1;
                state <= H_HDR;
              end else begin
                pend_out <= 1'b0;
                state <= H_END;
              end
            end
          end
        end
        H_WTA: begin
          if (rise_ev) begin
            cnt <= 6'h00;
            wsh <= w0;
            pend_out <= w0[0]; // see RQ8
            pend_oe <= 1'b1;
            state <= H_WD;
          end
        end
        H_WD: begin
          if (rise_ev) begin
            wsh <= wsh >> 1;
            pend_out <= wsh[1];
            if (cnt == 6'(DATA_BITS - 1)) begin
              pend_out <= 1'b0;
              state <= H_END;
            end
          end
        end
        H_BACK: begin
          if (rise_ev && cnt == 6'(BACKOFF_BITS - 1)) begin
            cnt <= 6'h00;
            pend_oe <= 1'b1;
            if (!rnw && !redo) begin
              redo <= 1'b1;
              hdr <= hdr0; // see RQ14
              pend_out <= 1'b1;
              state <= H_HDR;
            end else begin
              pend_out <= 1'b0;
              state <= H_END;
            end
          end
        end
        H_END: begin
          if (fall_ev) begin
            rsp_valid <= 1'b1;
            cmd_ready <= 1'b1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.swclk = swclk;
  assign link.host_out = out;
  assign link.host_oe = oe;
endmodule : swafh_host

// *** test/swafh_chk.sv ***
// link protocol checker for the two-wire debug link
`timescale 1ns/1ps
module swafh_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic swclk,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  no_contention_a: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the line");
  reset_idle_a: assert property ($fell(rst) |-> !swclk && host_oe && !dev_oe)
    else $error("link not idle after reset");
  // half period of 5 clk cycles for the default divider
  half_period_a: assert property ($changed(swclk) |=> $stable(swclk)[*4])
    else $error("link clock half period too short");
  // first rise after a quiet clock must carry the start bit
  start_bit_a: assert property ($rose(swclk) && !$past(swclk, 10) |-> host_oe && line)
    else $error("frame opens without start bit");
  host_fall_a: assert property (host_oe && $changed(host_out) |-> !swclk)
    else $error("host data moved while clock high");
  ack_released_a: assert property ($rose(dev_oe) |-> swclk && !$past(host_oe, 4))
    else $error("port drove before turnaround");
  ack_stands_a: assert property ($rose(dev_oe) |=> dev_oe[*8])
    else $error("acknowledge cut short");
  release_bound_a: assert property ($rose(dev_oe) |-> ##[25:380] !dev_oe)
    else $error("port kept the line too long");
  cover property ($rose(dev_oe) && dev_out);
  cover property ($rose(dev_oe) ##40 dev_oe);
  cover property ($fell(dev_oe) ##1 !dev_oe);
endmodule : swafh_chk

// *** test/serial_wire_ack_fault_handling_tb.sv ***
// testbench: host and port back to back, plus a hand-driven second link
`timescale 1ns/1ps
module serial_wire_ack_fault_handling_tb;
  import swafh_pkg::*;
  typedef struct packed {
    logic ap; logic rnw; logic [1:0] a; logic [31:0] wd;
    logic [2:0] ack; logic chk; logic [31:0] ex;
  } swafh_row_s;
  localparam logic [31:0] ID = 32'h0C0F_FEE1; // arbitrary value
  localparam logic [31:0] APV = 32'h5A5A_0000;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sw2 = 1'b0, run2 = 1'b0;
  logic cmd_valid = 1'b0, cmd_apndp = 1'b0, cmd_rnw = 1'b0, orun_en = 1'b0;
  logic [1:0] cmd_addr = 2'h0;
  logic [31:0] cmd_wdata = 32'h0, ap_rdata = 32'h0;
  logic cmd_ready, rsp_valid, rsp_perr, ap_req, wflag, sflag, wflag2;
  logic [2:0] rsp_ack;
  logic [31:0] rsp_rdata;
  logic [1:0] ap_addr;
  logic ap_done = 1'b0, ap_err = 1'b0, ap_hold = 1'b0, err_mode = 1'b0, drove2 = 1'b0;
  int ap_cnt = 0, cycles = 0, miscompares = 0, compares = 0;
  swafh_row_s rows [8] = '{
    '{1'b0, 1'b1, 2'h0, 32'h0, ACK_OK, 1'b1, ID},
    '{1'b0, 1'b0, 2'h2, 32'h0, ACK_OK, 1'b0, 32'h0},
    '{1'b1, 1'b0, 2'h1, 32'h1357_9BDF, ACK_OK, 1'b0, 32'h0},
    '{1'b1, 1'b1, 2'h1, 32'h0, ACK_OK, 1'b0, 32'h0},
    '{1'b1, 1'b1, 2'h3, 32'h0, ACK_OK, 1'b1, APV | 32'h1},
    '{1'b0, 1'b1, 2'h3, 32'h0, ACK_OK, 1'b1, APV | 32'h3},
    '{1'b0, 1'b1, 2'h2, 32'h0, ACK_OK, 1'b1, APV | 32'h3},
    '{1'b0, 1'b1, 2'h1, 32'h0, ACK_OK, 1'b0, 32'h0}};
  swafh_link_if link_i ();
  swafh_link_if link_b_i ();
  swafh_host #(.HALF(5), .WAIT_RETRY(3)) swafh_host_i (.clk(clk), .rst(rst), .ce(ce),
    .link(link_i.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_apndp(cmd_apndp),
    .cmd_rnw(cmd_rnw), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .orun_en(orun_en),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .rsp_perr(rsp_perr));
  swafh_dev #(.ID_VALUE(ID)) swafh_dev_i (.clk(clk), .rst(rst), .ce(ce), .link(link_i.dev),
    .ap_req(ap_req), .ap_rnw(), .ap_addr(ap_addr), .ap_wdata(), .ap_done(ap_done),
    .ap_err(ap_err), .ap_rdata(ap_rdata), .write_parity_error_flag(wflag),
    .sticky_err_flag(sflag));
  // second port, its host side played by hand to break the framing
  swafh_dev #(.ID_VALUE(ID)) swafh_dev_b_i (.clk(clk), .rst(rst), .ce(ce),
    .link(link_b_i.dev), .ap_req(), .ap_rnw(), .ap_addr(), .ap_wdata(), .ap_done(1'b0),
    .ap_err(1'b0), .ap_rdata(32'h0), .write_parity_error_flag(wflag2), .sticky_err_flag());
  swafh_chk swafh_chk_i (.clk(clk), .rst(rst), .swclk(link_i.swclk),
    .host_out(link_i.host_out), .host_oe(link_i.host_oe), .dev_out(link_i.dev_out),
    .dev_oe(link_i.dev_oe), .line(link_i.line));
  assign link_b_i.swclk = sw2;
  always #2.5 clk = ~clk;
  // link clock runs while run2 is set and stands low otherwise
  always #24 sw2 = run2 ? ~sw2 : 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // access port stand-in; ap_hold keeps an access outstanding
  always @(posedge clk) begin
    ap_done <= 1'b0;
    if (ap_req) ap_cnt <= 4;
    else if (ap_cnt != 0 && !ap_hold) begin
      ap_cnt <= ap_cnt - 1;
      if (ap_cnt == 1) begin
        ap_done <= 1'b1;
        ap_err <= err_mode;
        ap_rdata <= APV | {30'h0, ap_addr};
      end
    end
  end
  always @(posedge clk) if (link_b_i.dev_oe === 1'b1) drove2 <= 1'b1;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] ex);
    compares++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask : check
  task automatic issue(input swafh_row_s r);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    {cmd_apndp, cmd_rnw, cmd_addr, cmd_wdata} <= {r.ap, r.rnw, r.a, r.wd};
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n == 4000) miscompares++;
    check({29'h0, rsp_ack}, {29'h0, r.ack});
    if (r.chk) begin
      check(rsp_rdata, r.ex);
      check({31'h0, rsp_perr}, 32'h0);
    end
  endtask : issue
  task automatic bit2(input logic oe, input logic b, output logic s);
    @(negedge sw2);
    link_b_i.host_oe = oe;
    link_b_i.host_out = b;
    @(posedge sw2);
    s = link_b_i.line;
  endtask : bit2
  task automatic frame2(input logic [7:0] h, input logic [32:0] wd, input logic wr,
                        output logic [2:0] ack);
    logic s;
    for (int i = 0; i < 8; i++) bit2(1'b1, h[i], s);
    for (int i = 0; i < 5; i++) begin
      bit2(1'b0, 1'b0, s);
      if (i >= 1 && i <= 3) ack[i-1] = s;
    end
    for (int i = 0; i < 33; i++) if (wr) bit2(1'b1, wd[i], s);
    @(negedge sw2);
    link_b_i.host_oe = 1'b1;
    link_b_i.host_out = 1'b0;
  endtask : frame2
  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] ack2;
    link_b_i.host_oe = 1'b1;
    link_b_i.host_out = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({28'h0, cmd_ready, rsp_valid, wflag, sflag}, 32'h8);
    foreach (rows[i]) issue(rows[i]);
    ap_hold = 1'b1;
    issue('{1'b1, 1'b1, 2'h0, 32'h0, ACK_OK, 1'b1, APV | 32'h3});
    issue('{1'b1, 1'b1, 2'h0, 32'h0, ACK_WAIT, 1'b0, 32'h0});
    // overrun detection on: a refused read still runs a zero data phase
    issue('{1'b0, 1'b0, 2'h1, 32'h1, ACK_OK, 1'b0, 32'h0});
    orun_en <= 1'b1;
    issue('{1'b1, 1'b1, 2'h0, 32'h0, ACK_WAIT, 1'b1, 32'h0});
    issue('{1'b0, 1'b0, 2'h0, 32'h10, ACK_OK, 1'b0, 32'h0});
    issue('{1'b0, 1'b0, 2'h1, 32'h0, ACK_OK, 1'b0, 32'h0});
    orun_en <= 1'b0;
    ap_hold = 1'b0;
    issue('{1'b0, 1'b1, 2'h3, 32'h0, ACK_OK, 1'b1, APV});
    err_mode = 1'b1;
    issue('{1'b1, 1'b0, 2'h0, 32'h0, ACK_OK, 1'b0, 32'h0});
    repeat (20) @(negedge clk);
    check({31'h0, sflag}, 32'h1);
    err_mode = 1'b0;
    issue('{1'b1, 1'b1, 2'h0, 32'h0, ACK_FAULT, 1'b0, 32'h0});
    issue('{1'b0, 1'b1, 2'h0, 32'h0, ACK_OK, 1'b1, ID});
    issue('{1'b0, 1'b0, 2'h0, 32'h4, ACK_OK, 1'b0, 32'h0});
    repeat (4) @(negedge clk);
    check({31'h0, sflag}, 32'h0);
    run2 = 1'b1;
    // header with its parity bit turned round
    frame2(8'h85, 33'h0, 1'b0, ack2);
    check({28'h0, drove2, ack2}, 32'h0);
    frame2(8'hB1, {1'b1, 32'h0}, 1'b1, ack2);
    check({29'h0, ack2}, {29'h0, ACK_OK});
    repeat (20) @(posedge clk);
    check({31'h0, wflag2}, 32'h1);
    run2 = 1'b0;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({28'h0, cmd_ready, rsp_valid, wflag2, sflag}, 32'h8);
    conclude();
  end
endmodule : serial_wire_ack_fault_handling_tb
